// file: src/iorw_top.sv
/*
 Register width access layer: configuration space of any width, register
 data ports sized by the current I/O mode, setup registers loaded from the
 init-block read and the serial EEPROM read.
 Assumes one access per cycle from a PCI target front end on the same clock.
*/
`timescale 1ns/1ns
// Operation
// [RL1] configuration accesses work at byte, word or dword width in any mode
// [RL2] word mode: non-configuration registers are 16 bits wide
// [RL3] dword mode: registers 32 bits wide, upper half mostly undefined
// [RL4] host writes zeros in upper 16 bits in dword mode
// [RL5] host ignores upper read half except chip identity register
// [RL6] init-block read loads the init setup set
// [RL7] EEPROM read can preload the marked setup registers
// [RL8] setup registers may be read and rewritten freely
// [RL9] hardware reset leaves word I/O mode
// [RL10] dword write to data port at 10h enters dword mode
// [RL11] width chosen per access from the mode flag at its start
module iorw_top (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// configuration access
	input wire logic cfg_req,
	input wire logic cfg_we,
	input wire logic [3:0] cfg_word,
	input wire logic [3:0] cfg_be_n,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata_ff,
	output logic cfg_ack_ff,
	// i/o access
	input wire logic io_req,
	input wire logic io_we,
	input wire logic [4:0] io_addr,
	input wire logic [3:0] io_be_n,
	input wire logic [31:0] io_wdata,
	output logic [31:0] io_rdata_ff,
	output logic io_ack_ff,
	// setup loaders
	input wire logic ld_valid,
	input wire logic ld_from_ee,
	input wire logic [iorw_pkg::IDX_W-1:0] ld_idx,
	input wire logic [15:0] ld_data,
	// mode
	output logic dword_io_mode_ff
);
	import iorw_pkg::*;
	logic [7:0] cfg_mem [CFG_WORDS][4];
	logic [15:0] regs [NREG];
	logic [IDX_W-1:0] ptr_ff;
	logic [15:0] lane_lo;
	logic lane_ok;

	function automatic logic in_set_init(input logic [IDX_W-1:0] i);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < N_INIT; k++) begin
			hit = hit | (INIT_IDX[k] == i);
		end
		return hit;
	endfunction
	function automatic logic in_set_ee(input logic [IDX_W-1:0] i);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < N_EE; k++) begin
			hit = hit | (EE_IDX[k] == i);
		end
		return hit;
	endfunction

	// mode is sampled at the request cycle, so each access sees its own width
	iorw_lane u_lane (
		.dword_io_mode(dword_io_mode_ff), // RL11
		.be_n(io_be_n),
		.wdata(io_wdata),
		.lo_data(lane_lo),
		.wr_ok(lane_ok)
	);

	wire is_data_port = (io_addr == OFS_DATA_PORT);
	wire enter_dw = io_req && io_we && is_data_port && (io_be_n == BE_ALL); // RL10
	// the pointer port moves with the mode; the data port keeps its offset
	wire is_ptr_port = dword_io_mode_ff ? (io_addr == OFS_PTR_PORT_D)
		: (io_addr == OFS_PTR_PORT_W); // RL2 RL3
	wire dw_now = dword_io_mode_ff || enter_dw;
	wire io_wr_data = io_req && io_we && is_data_port && (lane_ok || enter_dw);
	wire io_wr_ptr = io_req && io_we && is_ptr_port && lane_ok;
	wire ld_ok = ld_valid && (ld_from_ee ? in_set_ee(ld_idx) : in_set_init(ld_idx)); // RL6 RL7
	wire [15:0] cur_reg = regs[ptr_ff];
	// in dword mode the upper half reads zero except on the identity register
	wire [15:0] hi_half = (ptr_ff == IDX_IDENT) ? IDENT_HI : 16'h0000; // RL5
	wire [15:0] ptr_word = {9'h0, ptr_ff};
	wire [31:0] rd_word = dword_io_mode_ff ? {hi_half, (is_ptr_port ? ptr_word : cur_reg)}
		: {16'h0000, (is_ptr_port ? ptr_word : cur_reg)};
	wire [31:0] rd_steer = (!dword_io_mode_ff && io_be_n == BE_HI) ? {rd_word[15:0], 16'h0000}
		: rd_word; // RL2

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			dword_io_mode_ff <= 1'b0; // RL9
		end else if (enter_dw) begin
			dword_io_mode_ff <= 1'b1; // RL10
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ptr_ff <= '0;
		end else if (io_wr_ptr) begin
			ptr_ff <= lane_lo[IDX_W-1:0];
		end
	end

	// host data port wins over a loader in the same cycle; RL8 allows rewrite
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < NREG; i++) begin
				regs[i] <= SETUP_RST;
			end
		end else if (io_wr_data) begin
			regs[ptr_ff] <= dw_now ? io_wdata[15:0] : lane_lo; // RL8 RL4
		end else if (ld_ok) begin
			regs[ld_idx] <= ld_data; // RL6 RL7
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			io_rdata_ff <= 32'h0000_0000;
			io_ack_ff <= 1'b0;
		end else begin
			io_ack_ff <= io_req;
			io_rdata_ff <= (io_req && !io_we) ? rd_steer : 32'h0000_0000; // RL3
		end
	end

	// configuration space honours each byte enable, independent of mode
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			for (int w = 0; w < CFG_WORDS; w++) begin
				for (int b = 0; b < 4; b++) begin
					cfg_mem[w][b] <= CFG_RST[7:0];
				end
			end
		end else if (cfg_req && cfg_we) begin
			for (int b = 0; b < 4; b++) begin
				if (!cfg_be_n[b]) begin
					cfg_mem[cfg_word][b] <= cfg_wdata[8*b +: 8]; // RL1
				end
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cfg_rdata_ff <= 32'h0000_0000;
			cfg_ack_ff <= 1'b0;
		end else begin
			cfg_ack_ff <= cfg_req;
			for (int b = 0; b < 4; b++) begin
				cfg_rdata_ff[8*b +: 8] <= (cfg_req && !cfg_we && !cfg_be_n[b])
					? cfg_mem[cfg_word][b] : 8'h00; // RL1
			end
		end
	end

	property p_reset_word;
		@(posedge clock) $rose(nrst) |-> !dword_io_mode_ff;
	endproperty
	a_reset_word: assert property (p_reset_word) else $error("not word mode after reset"); // RL9

	property p_enter_dw;
		@(posedge clock) disable iff (!nrst) enter_dw |=> dword_io_mode_ff;
	endproperty
	a_enter_dw: assert property (p_enter_dw) else $error("dword write missed mode"); // RL10

	property p_dw_sticky;
		@(posedge clock) disable iff (!nrst) dword_io_mode_ff |=> dword_io_mode_ff;
	endproperty
	a_dw_sticky: assert property (p_dw_sticky) else $error("dword mode dropped"); // RL3

	property p_word_hi_zero;
		@(posedge clock) disable iff (!nrst)
		(io_req && !io_we && !dword_io_mode_ff && io_be_n == BE_LO) |=> io_rdata_ff[31:16] == 16'h0;
	endproperty
	a_word_hi_zero: assert property (p_word_hi_zero) else $error("word read upper half"); // RL2

	property p_ident_hi;
		@(posedge clock) disable iff (!nrst)
		(io_req && !io_we && dword_io_mode_ff && is_data_port && ptr_ff == IDX_IDENT)
			|=> io_rdata_ff[31:16] == IDENT_HI;
	endproperty
	a_ident_hi: assert property (p_ident_hi) else $error("identity upper half"); // RL5

	property p_cfg_byte;
		@(posedge clock) disable iff (!nrst)
		(cfg_req && !cfg_we && cfg_be_n == 4'he) |=> cfg_rdata_ff[31:8] == 24'h0 && cfg_ack_ff;
	endproperty
	a_cfg_byte: assert property (p_cfg_byte) else $error("cfg byte read lanes"); // RL1

	property p_load;
		@(posedge clock) disable iff (!nrst)
		(ld_ok && !io_wr_data) |=> regs[$past(ld_idx)] == $past(ld_data);
	endproperty
	a_load: assert property (p_load) else $error("setup load lost"); // RL6

	property p_rewrite;
		@(posedge clock) disable iff (!nrst)
		(io_wr_data && dword_io_mode_ff) |=> regs[$past(ptr_ff)] == $past(io_wdata[15:0]);
	endproperty
	a_rewrite: assert property (p_rewrite) else $error("data port write lost"); // RL8

	property p_ack;
		@(posedge clock) disable iff (!nrst) io_req |=> io_ack_ff;
	endproperty
	a_ack: assert property (p_ack) else $error("io ack missing"); // RL11

	c_enter: cover property (@(posedge clock) disable iff (!nrst) enter_dw);
	c_ee: cover property (@(posedge clock) disable iff (!nrst) ld_ok && ld_from_ee);
	c_cfg: cover property (@(posedge clock) disable iff (!nrst) cfg_req && cfg_we);
	c_dwrd: cover property (@(posedge clock) disable iff (!nrst) dword_io_mode_ff && io_req);
endmodule

// file: include/iorw_pkg.sv
/*
 Constants shared by the register width access layer: I/O offsets, register
 indices of the setup set, widths and reset values.
 Assumes a 32-bit host data path with active-low byte enables.
*/
package iorw_pkg;
	localparam logic [4:0] OFS_DATA_PORT = 5'h10;
	localparam logic [4:0] OFS_PTR_PORT_W = 5'h12;
	localparam logic [4:0] OFS_BUS_PORT_W = 5'h16;
	localparam logic [4:0] OFS_PTR_PORT_D = 5'h14;
	localparam logic [4:0] OFS_BUS_PORT_D = 5'h1c;
	localparam logic [3:0] BE_ALL = 4'h0;
	localparam logic [3:0] BE_LO = 4'hc;
	localparam logic [3:0] BE_HI = 4'h3;
	localparam int IDX_W = 7;
	localparam logic [6:0] IDX_IDENT = 7'h58;
	localparam logic [15:0] SETUP_RST = 16'h0000;
	// identity upper half: the value is arbitrary, only its presence matters
	localparam logic [15:0] IDENT_HI = 16'h1234;
	// setup set loaded by the init-block read, as register indices
	localparam int N_INIT = 17;
	localparam logic [6:0] INIT_IDX [N_INIT] = '{7'h02, 7'h08, 7'h09, 7'h0a, 7'h0b,
		7'h0c, 7'h0d, 7'h0e, 7'h0f, 7'h18, 7'h19, 7'h1e, 7'h1f, 7'h2f, 7'h31,
		7'h4c, 7'h4e};
	localparam int N_EE = 3;
	localparam logic [6:0] EE_IDX [N_EE] = '{7'h0c, 7'h0d, 7'h0e};
	localparam int CFG_WORDS = 16;
	localparam logic [15:0] CFG_RST = 16'h0000;
	localparam int NREG = 128;
endpackage

// file: src/iorw_lane.sv
/*
 Lane steering for one access: picks the 16 or 32 bit view of a register
 from the double-word flag sampled at the start of the access.
 Assumes data and byte enables come from logic on the same clock.
*/
`timescale 1ns/1ns
module iorw_lane (
	// access
	input wire logic dword_io_mode,
	input wire logic [3:0] be_n,
	input wire logic [31:0] wdata,
	// result
	output logic [15:0] lo_data,
	output logic wr_ok
);
	import iorw_pkg::*;
	wire lo_sel = (be_n[1:0] == 2'h0);
	wire hi_sel = (be_n[3:2] == 2'h0) && !lo_sel;
	// in dword mode the upper half is ignored; host writes zero there
	assign lo_data = dword_io_mode ? wdata[15:0] : (hi_sel ? wdata[31:16] : wdata[15:0]);
	assign wr_ok = dword_io_mode ? (be_n == BE_ALL) : (lo_sel ^ hi_sel);
endmodule

// file: dv/iorw_host.sv
/* Host model: one config or i/o request at a time, plus setup loads.
 Assumes the device answers at the edge taking a request, read back at the next falling edge. */
`timescale 1ns/1ns
module iorw_host (
	// answers
	input wire logic clock,
	input wire logic dword_io_mode_ff,
	input wire logic cfg_ack_ff,
	input wire logic io_ack_ff,
	input wire logic [31:0] cfg_rdata_ff,
	input wire logic [31:0] io_rdata_ff,
	// requests
	output logic cfg_req,
	output logic io_req,
	output logic we,
	output logic ld_valid,
	output logic ld_from_ee,
	output logic [4:0] addr,
	output logic [3:0] be_n,
	output logic [31:0] wdata,
	output logic [6:0] ld_idx,
	output logic [15:0] ld_data
);
	initial begin
		{cfg_req, io_req, we, ld_valid, ld_from_ee, addr, be_n, ld_idx, ld_data} = '0;
		wdata = '0;
	end
	task automatic xfer(input logic c, w, input logic [4:0] a, input logic [3:0] b,
		input logic [31:0] d, input logic hi, output logic [31:0] q, output logic k);
		@(negedge clock);
		{cfg_req, io_req, we, addr, be_n} = {c, !c, w, a, b};
		wdata = (dword_io_mode_ff && !c) ? {16'h0000, d[15:0]} : d;
		@(negedge clock);
		{cfg_req, io_req} = 2'b00;
		// released data must not look still valid
		wdata = ~wdata;
		q = c ? cfg_rdata_ff : io_rdata_ff;
		k = c ? cfg_ack_ff : io_ack_ff;
		// upper half only counts when the caller sets hi, as for the identity register
		if (!hi && !c && dword_io_mode_ff) q[31:16] = 16'h0000;
	endtask
	task automatic load(input logic ee, input logic [6:0] i, input logic [15:0] d);
		@(negedge clock);
		{ld_valid, ld_from_ee, ld_idx, ld_data} = {1'b1, ee, i, d};
		@(negedge clock);
		ld_valid = 1'b0;
	endtask
endmodule

// file: dv/iorw_top_tb.sv
/* Self-checking bench for the register width access layer.
 Assumes the host model drives every request at the falling edge. */
`timescale 1ns/1ns
module iorw_top_tb;
	import iorw_pkg::*;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic cfg_req, io_req, we, ld_valid, ld_from_ee, cfg_ack_ff, io_ack_ff, mode;
	logic [4:0] addr;
	logic [3:0] be_n;
	logic [31:0] wdata, cfg_rdata_ff, io_rdata_ff, q;
	logic [6:0] ld_idx;
	logic [15:0] ld_data;
	int n_errors = 0;
	int n_checks = 0;
	always #25 clock = ~clock;
	iorw_top uut (.clock(clock), .nrst(nrst), .cfg_req(cfg_req), .cfg_we(we),
		.cfg_word(addr[3:0]), .cfg_be_n(be_n), .cfg_wdata(wdata), .cfg_rdata_ff(cfg_rdata_ff),
		.cfg_ack_ff(cfg_ack_ff), .io_req(io_req), .io_we(we), .io_addr(addr), .io_be_n(be_n),
		.io_wdata(wdata), .io_rdata_ff(io_rdata_ff), .io_ack_ff(io_ack_ff),
		.ld_valid(ld_valid), .ld_from_ee(ld_from_ee), .ld_idx(ld_idx), .ld_data(ld_data),
		.dword_io_mode_ff(mode));
	iorw_host host (.clock(clock), .dword_io_mode_ff(mode), .cfg_ack_ff(cfg_ack_ff),
		.io_ack_ff(io_ack_ff), .cfg_rdata_ff(cfg_rdata_ff), .io_rdata_ff(io_rdata_ff),
		.cfg_req(cfg_req), .io_req(io_req), .we(we), .ld_valid(ld_valid),
		.ld_from_ee(ld_from_ee), .addr(addr), .be_n(be_n), .wdata(wdata), .ld_idx(ld_idx),
		.ld_data(ld_data));
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic acc(input logic c, w, input logic [4:0] a, input logic [3:0] b,
		input logic [31:0] d, input logic hi = 1'b0);
		logic k;
		host.xfer(c, w, a, b, d, hi, q, k);
		chk("ack", 1, k);
	endtask
	// ports and lanes follow the mode in force when the access starts
	task automatic reg_acc(input logic w, input logic [6:0] i, input logic [15:0] d,
		input logic hi = 1'b0);
		if (mode) begin
			acc(0, 1, OFS_PTR_PORT_D, BE_ALL, {25'h0, i});
			acc(0, w, OFS_DATA_PORT, BE_ALL, {16'h0, d}, hi);
		end else begin
			acc(0, 1, OFS_PTR_PORT_W, BE_HI, {9'h0, i, 16'h0});
			acc(0, w, OFS_DATA_PORT, BE_LO, {16'h0, d});
		end
	endtask
	task automatic t_cfg(input logic [3:0] b, input logic [31:0] e);
		acc(1, 1, 5'h03, BE_ALL, 32'h11223344);
		acc(1, 0, 5'h03, b, 0);
		chk("cfg", e, q);
		$display("test cfg done");
	endtask
	task automatic t_word;
		reg_acc(1, 7'h0f, 16'h0a5a);
		reg_acc(0, 7'h0f, 0);
		chk("word data", 16'h0a5a, q[15:0]);
		acc(0, 0, OFS_PTR_PORT_W, BE_HI, 0);
		chk("word addr", 16'h000f, q[31:16]);
		$display("test word done");
	endtask
	task automatic t_load;
		host.load(0, 7'h0c, 16'h1111);
		reg_acc(0, 7'h0c, 0);
		chk("init load", 16'h1111, q[15:0]);
		host.load(1, 7'h0d, 16'h2222);
		reg_acc(0, 7'h0d, 0);
		chk("ee load", 16'h2222, q[15:0]);
		host.load(1, 7'h0f, 16'h3333);
		reg_acc(0, 7'h0f, 0);
		chk("ee outside set", 16'h0a5a, q[15:0]);
		$display("test load done");
	endtask
	task automatic t_dword;
		acc(0, 1, OFS_DATA_PORT, BE_ALL, 32'h00000077);
		chk("mode set", 1, mode);
		reg_acc(0, 7'h0f, 0, 1);
		chk("dword data", 32'h00000077, q);
		reg_acc(1, 7'h0f, 16'h5aa5);
		reg_acc(0, 7'h0f, 0);
		chk("rewrite", 16'h5aa5, q);
		reg_acc(0, IDX_IDENT, 0, 1);
		chk("ident hi", IDENT_HI, q[31:16]);
		$display("test dword done");
	endtask
	// a mid-run hardware reset is the only way out of dword mode
	task automatic t_reset;
		@(negedge clock);
		nrst = 1'b0;
		repeat (2) @(negedge clock);
		nrst = 1'b1;
		chk("reset mode again", 0, mode);
		reg_acc(0, 7'h0f, 0);
		chk("reset regs", SETUP_RST, q[15:0]);
		$display("test reset done");
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(negedge clock);
		nrst = 1'b1;
		chk("reset mode", 0, mode);
		t_cfg(4'he, 32'h00000044);
		t_word;
		t_load;
		t_dword;
		t_cfg(4'hd, 32'h00003300);
		t_reset;
		test_done;
	end
	initial begin
		#(2000 * 50);
		n_errors++;
		test_done;
	end
endmodule
